// file: design/jmip_cfg.svh
// Constants for the JESD204C mode decode and alignment-sequence parameter block
// Operation
// - Dual-input interleave samples at twice clock, cores out of phase, own inputs.
// - Dual-input interleave only for a single-channel mode with both inputs selected.
// - Dual-input interleave leaves digital chain and link as in single-channel.
// - Link mode select alone derives all transport parameters and channel count.
// - Interleave flag is one for single-channel modes, zero for dual-channel.
// - Bits-per-clock ratio sets serial bits per lane per device clock.
// - Bits-per-clock ratio selects serializer PLL factor or PLL bypass.
// - Frames per multiframe from register, used in 8b/10b, ignored in 64b/66b.
// - Multiblocks per extended multiblock fixed at one, used only in 64b/66b.
// - In 8b/10b every transport parameter but control bits per sample is sent in the alignment sequence.
// - In 64b/66b no alignment sequence, transport still uses same parameters.
// - Adjust count, direction, bank, control words, density, reserved sent zero.
// - Control-bits-per-sample field reported zero even when bits are carried.
// - Standard revision and subclass version fields are both one.
// - Device identifier written by host and transmitted unchanged.
// - Scrambler field follows the link control register setting.
// - Checksum is the sum of all other fields modulo 256.
// - Each lane sends its own lane identifier from the lane assignment.
// - Converter count describes lane packing, may differ from channels in use.
// - Octets, lanes, resolution, bits per sample, samples derive from mode.
// - Only mode-allowed frames-per-multiframe values may be programmed; other values are still accepted and only flagged in status.
`ifndef JMIP_CFG_SVH
`define JMIP_CFG_SVH

`define JMIP_ADDR_CTRL    12'h000
`define JMIP_ADDR_MODE    12'h004
`define JMIP_ADDR_KPARAM  12'h008
`define JMIP_ADDR_DEVID   12'h00C
`define JMIP_ADDR_INSEL   12'h010
`define JMIP_ADDR_STATUS  12'h014
`define JMIP_ADDR_XPORT   12'h018
`define JMIP_ADDR_RATE    12'h01C

`define JMIP_CTRL_LINK_EN 0
`define JMIP_CTRL_SCR_EN  1

`define JMIP_STAT_ACTIVE  0
`define JMIP_STAT_DES     1
`define JMIP_STAT_DUAL    2
`define JMIP_STAT_BADMODE 3
`define JMIP_STAT_BADK    4
`define JMIP_STAT_ENC64   5

`define JMIP_RST_MODE     6'h00
`define JMIP_RST_KFM      8'h1F
`define JMIP_RST_DID      8'h00
`define JMIP_RST_INSEL    2'h0

`define JMIP_JESDV        3'h1
`define JMIP_SUBCLASSV    3'h1
`define JMIP_EMB_E        8'h01

`endif

// file: design/jmip_mode_rom.sv
// Link mode table: derives every transport parameter from the mode code
`timescale 1ns/1ps
`default_nettype none

module jmip_mode_rom
    import jmip_pkg::*;
#(
    parameter int MW = 6
) (
    // Mode code in, derived parameters out
    input  wire logic [MW-1:0] mode_i,
    output var  jmip_mode_s    cfg_o
);

    // Fields: des, L, M, F, S, N, N', CS, R in eighths, K min, log2 K step
    function automatic jmip_mode_s row(
        input logic       des,
        input logic [3:0] l,
        input logic [3:0] m,
        input logic [3:0] f,
        input logic [3:0] s,
        input logic [4:0] n,
        input logic [4:0] np,
        input logic [1:0] cs,
        input logic [5:0] r8,
        input logic [5:0] kmin,
        input logic [2:0] klg
    );
        row = '{1'b1, 1'b0, des, l, m, f, s, n, np, cs, r8, kmin, klg};
    endfunction

    always_comb begin
        cfg_o = '0;
        case (mode_i)
            6'h00: cfg_o = row(1'h1, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0C, 5'h0C, 2'h0, 6'h20, 6'h04, 3'h1);
            6'h01: cfg_o = row(1'h1, 4'h8, 4'h8, 4'h8, 4'h5, 5'h0C, 5'h0C, 2'h0, 6'h10, 6'h04, 3'h1);
            6'h02: cfg_o = row(1'h0, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0C, 5'h0C, 2'h0, 6'h20, 6'h04, 3'h1);
            6'h03: cfg_o = row(1'h0, 4'h8, 4'h8, 4'h8, 4'h5, 5'h0C, 5'h0C, 2'h0, 6'h10, 6'h04, 3'h1);
            6'h05: cfg_o = row(1'h1, 4'h4, 4'h1, 4'h1, 4'h4, 5'h08, 5'h08, 2'h0, 6'h14, 6'h20, 3'h4);
            6'h06: cfg_o = row(1'h1, 4'h8, 4'h1, 4'h1, 4'h8, 5'h08, 5'h08, 2'h0, 6'h0A, 6'h20, 3'h4);
            6'h07: cfg_o = row(1'h0, 4'h4, 4'h1, 4'h1, 4'h4, 5'h08, 5'h08, 2'h0, 6'h14, 6'h20, 3'h4);
            6'h08: cfg_o = row(1'h0, 4'h8, 4'h1, 4'h1, 4'h8, 5'h08, 5'h08, 2'h0, 6'h0A, 6'h20, 3'h4);
            6'h0A: cfg_o = row(1'h0, 4'h2, 4'h2, 4'h2, 4'h1, 5'h0F, 5'h10, 2'h1, 6'h28, 6'h10, 3'h3);
            6'h0B: cfg_o = row(1'h0, 4'h4, 4'h2, 4'h2, 4'h2, 5'h0F, 5'h10, 2'h1, 6'h14, 6'h10, 3'h3);
            6'h0C: cfg_o = row(1'h0, 4'h8, 4'h2, 4'h2, 4'h4, 5'h0F, 5'h10, 2'h1, 6'h0A, 6'h10, 3'h3);
            6'h0D: cfg_o = row(1'h0, 4'h1, 4'h2, 4'h4, 4'h1, 5'h0F, 5'h10, 2'h1, 6'h28, 6'h08, 3'h2);
            6'h0E: cfg_o = row(1'h0, 4'h2, 4'h2, 4'h2, 4'h1, 5'h0F, 5'h10, 2'h1, 6'h14, 6'h10, 3'h3);
            6'h0F: cfg_o = row(1'h0, 4'h4, 4'h2, 4'h2, 4'h2, 5'h0F, 5'h10, 2'h1, 6'h0A, 6'h10, 3'h3);
            6'h10: cfg_o = row(1'h0, 4'h8, 4'h2, 4'h2, 4'h4, 5'h0F, 5'h10, 2'h1, 6'h05, 6'h10, 3'h3);
            6'h13: cfg_o = row(1'h1, 4'h6, 4'h1, 4'h2, 4'h8, 5'h0C, 5'h0C, 2'h0, 6'h14, 6'h10, 3'h3);
            6'h14: cfg_o = row(1'h0, 4'h6, 4'h1, 4'h2, 4'h8, 5'h0C, 5'h0C, 2'h0, 6'h14, 6'h10, 3'h3);
            6'h15: cfg_o = row(1'h1, 4'h2, 4'h1, 4'h2, 4'h2, 5'h0F, 5'h10, 2'h1, 6'h28, 6'h10, 3'h3);
            6'h16: cfg_o = row(1'h1, 4'h4, 4'h1, 4'h2, 4'h4, 5'h0F, 5'h10, 2'h1, 6'h14, 6'h10, 3'h3);
            6'h17: cfg_o = row(1'h1, 4'h1, 4'h1, 4'h2, 4'h1, 5'h0F, 5'h10, 2'h1, 6'h28, 6'h10, 3'h3);
            6'h18: cfg_o = row(1'h1, 4'h2, 4'h1, 4'h2, 4'h2, 5'h0F, 5'h10, 2'h1, 6'h14, 6'h10, 3'h3);
            6'h19: cfg_o = row(1'h1, 4'h8, 4'h1, 4'h2, 4'h8, 5'h0F, 5'h10, 2'h1, 6'h0A, 6'h10, 3'h3);
            6'h1A: cfg_o = row(1'h1, 4'h4, 4'h1, 4'h2, 4'h4, 5'h0F, 5'h10, 2'h1, 6'h0A, 6'h10, 3'h3);
            6'h1B: cfg_o = row(1'h1, 4'h8, 4'h1, 4'h2, 4'h8, 5'h0F, 5'h10, 2'h1, 6'h05, 6'h10, 3'h3);
            default: cfg_o = '0;
        endcase
    end

endmodule

`default_nettype wire

// file: design/jmip_pkg.sv
// Types shared by the mode decode and alignment-sequence parameter block
package jmip_pkg;

    typedef struct packed {
        logic       valid;
        logic       enc64;
        logic       des;
        logic [3:0] l;
        logic [3:0] m;
        logic [3:0] f;
        logic [3:0] s;
        logic [4:0] n;
        logic [4:0] np;
        logic [1:0] cs;
        logic [5:0] r8;
        logic [5:0] kmin;
        logic [2:0] kstep_lg;
    } jmip_mode_s;

    typedef enum logic [1:0] {
        JMIP_IN_A    = 2'h0,
        JMIP_IN_B    = 2'h1,
        JMIP_IN_BOTH = 2'h2
    } jmip_insel_e;

    typedef enum logic {
        JMIP_LINK_OFF = 1'b0,
        JMIP_LINK_ON  = 1'b1
    } jmip_link_e;

endpackage

// file: design/jmip_top.sv
// JESD204C mode decode, link parameter hold and alignment-sequence octet source
`timescale 1ns/1ps
`default_nettype none
`include "jmip_cfg.svh"

module jmip_top
    import jmip_pkg::*;
#(
    parameter int         AW        = 12,
    parameter int         MW        = 6,
    parameter logic [5:0] BYPASS_R8 = 6'h00
) (
    // Clock and reset
    input  wire logic          CLK_I,
    input  wire logic          NRST_I,
    // APB slave
    input  wire logic          PSEL_I,
    input  wire logic          PENABLE_I,
    input  wire logic          PWRITE_I,
    input  wire logic [AW-1:0] PADDR_I,
    input  wire logic [31:0]   PWDATA_I,
    input  wire logic [3:0]    PSTRB_I,
    output logic      [31:0]   PRDATA_O,
    output logic               PREADY_O,
    output logic               PSLVERR_O,
    // Alignment-sequence octet lookup from the lane framers
    input  wire logic [3:0]    ILAS_LANE_I,
    input  wire logic [3:0]    ILAS_IDX_I,
    output logic      [7:0]    ILAS_OCTET_O,
    // Link control
    output logic               LINK_ACTIVE_O,
    output logic               ILAS_EN_O,
    output logic               ENC_64B66B_O,
    output logic               SCR_EN_O,
    output logic      [7:0]    LMFC_KFM_O,
    output logic      [7:0]    MB_PER_EMB_O,
    // Transport format
    output logic               DES_O,
    output logic      [3:0]    LANES_O,
    output logic      [3:0]    CONVS_O,
    output logic      [3:0]    OCTETS_O,
    output logic      [3:0]    SAMPLES_O,
    output logic      [4:0]    RES_O,
    output logic      [4:0]    NPRIME_O,
    output logic      [1:0]    CTRL_BITS_O,
    // Serializer PLL
    output logic      [5:0]    PLL_R8_O,
    output logic               PLL_BYPASS_O,
    // Converter cores
    output logic               ADC_A_SRC_O,
    output logic               ADC_B_SRC_O,
    output logic               ADC_B_PHASE_INV_O,
    output logic               DUAL_INTLV_O
);

    // Bus phase decode
    logic          setup_w;
    logic          access_w;
    logic          wr_w;
    logic          mapped_w;
    logic [31:0]   rd_w;
    logic          pready_q;
    logic          pslverr_q;
    logic [31:0]   prdata_q;

    // Software-written settings, not yet applied
    logic          link_en_q;
    logic          scr_q;
    logic [MW-1:0] mode_q;
    logic [7:0]    kfm_q;
    logic [7:0]    did_q;
    logic [1:0]    insel_q;

    // Settings applied at link enable
    jmip_link_e    state_q;
    logic [MW-1:0] act_mode_q;
    logic          act_scr_q;
    logic [7:0]    act_kfm_q;
    logic [7:0]    act_did_q;
    logic [1:0]    act_insel_q;

    // Derived parameters
    jmip_mode_s    rom_w;
    jmip_mode_s    xp_q;
    logic [8:0]    k_w;
    logic [8:0]    kmask_w;
    logic          k_bad_w;
    logic          sel_b_w;
    logic          sel_both_w;
    logic          active_w;
    logic [3:0]    lid_w;
    logic [7:0]    chk_w;
    logic [7:0]    octet_w;

    assign setup_w  = PSEL_I & ~PENABLE_I;
    assign access_w = PSEL_I & PENABLE_I & pready_q;
    assign wr_w     = access_w & PWRITE_I & PSTRB_I[0];

    always_comb begin
        mapped_w = 1'b1;
        rd_w     = 32'h0000_0000;
        case (PADDR_I)
            `JMIP_ADDR_CTRL: begin
                rd_w[`JMIP_CTRL_LINK_EN] = link_en_q;
                rd_w[`JMIP_CTRL_SCR_EN]  = scr_q;
            end
            `JMIP_ADDR_MODE: begin
                rd_w[MW-1:0] = mode_q;
            end
            `JMIP_ADDR_KPARAM: begin
                rd_w[7:0] = kfm_q;
            end
            `JMIP_ADDR_DEVID: begin
                rd_w[7:0] = did_q;
            end
            `JMIP_ADDR_INSEL: begin
                rd_w[1:0] = insel_q;
            end
            `JMIP_ADDR_STATUS: begin
                rd_w[`JMIP_STAT_ACTIVE]  = LINK_ACTIVE_O;
                rd_w[`JMIP_STAT_DES]     = DES_O;
                rd_w[`JMIP_STAT_DUAL]    = DUAL_INTLV_O;
                rd_w[`JMIP_STAT_BADMODE] = ~xp_q.valid;
                rd_w[`JMIP_STAT_BADK]    = k_bad_w;
                rd_w[`JMIP_STAT_ENC64]   = xp_q.enc64;
            end
            `JMIP_ADDR_XPORT: begin
                rd_w = {xp_q.cs, 1'b0, xp_q.np, 3'h0, xp_q.n,
                        xp_q.s, xp_q.f, xp_q.m, xp_q.l};
            end
            `JMIP_ADDR_RATE: begin
                rd_w[5:0] = xp_q.r8;
                rd_w[6]   = PLL_BYPASS_O;
            end
            default: begin
                mapped_w = 1'b0;
            end
        endcase
    end

    // Zero-wait slave: ready rises for the first access cycle
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup_w;
            pslverr_q <= setup_w & ~mapped_w;
            if (setup_w && !PWRITE_I) begin
                prdata_q <= rd_w;
            end else if (access_w) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // Register writes, byte lane 0 only
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            link_en_q <= 1'b0;
            scr_q     <= 1'b0;
            mode_q    <= `JMIP_RST_MODE;
            kfm_q     <= `JMIP_RST_KFM;
            did_q     <= `JMIP_RST_DID;
            insel_q   <= `JMIP_RST_INSEL;
        end else if (wr_w) begin
            case (PADDR_I)
                `JMIP_ADDR_CTRL: begin
                    link_en_q <= PWDATA_I[`JMIP_CTRL_LINK_EN];
                    scr_q     <= PWDATA_I[`JMIP_CTRL_SCR_EN];
                end
                `JMIP_ADDR_MODE:   mode_q  <= PWDATA_I[MW-1:0];
                `JMIP_ADDR_KPARAM: kfm_q   <= PWDATA_I[7:0];
                `JMIP_ADDR_DEVID:  did_q   <= PWDATA_I[7:0];
                `JMIP_ADDR_INSEL:  insel_q <= PWDATA_I[1:0];
                default: begin
                end
            endcase
        end
    end

    // Link state
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_q <= JMIP_LINK_OFF;
        end else begin
            case (state_q)
                JMIP_LINK_OFF: begin
                    if (link_en_q) begin
                        state_q <= JMIP_LINK_ON;
                    end
                end
                JMIP_LINK_ON: begin
                    if (!link_en_q) begin
                        state_q <= JMIP_LINK_OFF;
                    end
                end
                default: state_q <= JMIP_LINK_OFF;
            endcase
        end
    end

    // Settings track software only while off, so the set is settled at link up
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            act_mode_q  <= `JMIP_RST_MODE;
            act_scr_q   <= 1'b0;
            act_kfm_q   <= `JMIP_RST_KFM;
            act_did_q   <= `JMIP_RST_DID;
            act_insel_q <= `JMIP_RST_INSEL;
        end else if (state_q == JMIP_LINK_OFF) begin
            act_mode_q  <= mode_q;
            act_scr_q   <= scr_q;
            act_kfm_q   <= kfm_q;
            act_did_q   <= did_q;
            act_insel_q <= insel_q;
        end
    end

    jmip_mode_rom #(
        .MW     (MW)
    ) u_rom (
        .mode_i (act_mode_q),
        .cfg_o  (rom_w)
    );

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            xp_q <= '0;
        end else begin
            xp_q <= rom_w;
        end
    end

    // Frames per multiframe must reach the minimum and fall on the step
    assign k_w     = {1'b0, act_kfm_q} + 9'h001;
    assign kmask_w = (9'h001 << xp_q.kstep_lg) - 9'h001;
    assign k_bad_w = ~xp_q.enc64 & ((k_w < {3'h0, xp_q.kmin}) | ((k_w & kmask_w) != 9'h000));

    assign sel_b_w    = (act_insel_q == JMIP_IN_B);
    assign sel_both_w = (act_insel_q == JMIP_IN_BOTH);
    assign active_w   = (state_q == JMIP_LINK_ON) & xp_q.valid;

    // Lane identifier restarts in the second link
    assign lid_w = (ILAS_LANE_I < xp_q.l) ? ILAS_LANE_I : ILAS_LANE_I - xp_q.l;

    always_comb begin
        chk_w = act_did_q + {4'h0, lid_w} + {7'h00, act_scr_q}
              + {4'h0, xp_q.l - 4'h1} + {4'h0, xp_q.f - 4'h1} + act_kfm_q
              + {4'h0, xp_q.m - 4'h1} + {3'h0, xp_q.n - 5'h01}
              + {5'h00, `JMIP_SUBCLASSV} + {3'h0, xp_q.np - 5'h01}
              + {5'h00, `JMIP_JESDV} + {4'h0, xp_q.s - 4'h1};
    end

    always_comb begin
        octet_w = 8'h00;
        case (ILAS_IDX_I)
            4'h0: octet_w = act_did_q;
            4'h1: octet_w = 8'h00;
            4'h2: octet_w = {4'h0, lid_w};
            4'h3: octet_w = {act_scr_q, 3'h0, xp_q.l - 4'h1};
            4'h4: octet_w = {4'h0, xp_q.f - 4'h1};
            4'h5: octet_w = act_kfm_q;
            4'h6: octet_w = {4'h0, xp_q.m - 4'h1};
            4'h7: octet_w = {3'h0, xp_q.n - 5'h01};
            4'h8: octet_w = {`JMIP_SUBCLASSV, xp_q.np - 5'h01};
            4'h9: octet_w = {`JMIP_JESDV, 1'b0, xp_q.s - 4'h1};
            4'hA: octet_w = 8'h00;
            4'hB: octet_w = 8'h00;
            4'hC: octet_w = 8'h00;
            4'hD: octet_w = chk_w;
            default: octet_w = 8'h00;
        endcase
    end

    // Registered link outputs and alignment-sequence octet
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            LINK_ACTIVE_O <= 1'b0;
            ILAS_EN_O     <= 1'b0;
            ENC_64B66B_O  <= 1'b0;
            SCR_EN_O      <= 1'b0;
            LMFC_KFM_O    <= 8'h00;
            MB_PER_EMB_O  <= 8'h00;
            ILAS_OCTET_O  <= 8'h00;
        end else begin
            LINK_ACTIVE_O <= active_w;
            ILAS_EN_O     <= active_w & ~xp_q.enc64;
            ENC_64B66B_O  <= xp_q.enc64;
            SCR_EN_O      <= act_scr_q;
            LMFC_KFM_O    <= xp_q.enc64 ? 8'h00 : act_kfm_q;
            MB_PER_EMB_O  <= xp_q.enc64 ? `JMIP_EMB_E : 8'h00;
            ILAS_OCTET_O  <= octet_w;
        end
    end

    // Transport format, same set in both encodings
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            DES_O       <= 1'b0;
            LANES_O     <= 4'h0;
            CONVS_O     <= 4'h0;
            OCTETS_O    <= 4'h0;
            SAMPLES_O   <= 4'h0;
            RES_O       <= 5'h00;
            NPRIME_O    <= 5'h00;
            CTRL_BITS_O <= 2'h0;
        end else begin
            DES_O       <= xp_q.des;
            LANES_O     <= xp_q.l;
            CONVS_O     <= xp_q.m;
            OCTETS_O    <= xp_q.f;
            SAMPLES_O   <= xp_q.s;
            RES_O       <= xp_q.n;
            NPRIME_O    <= xp_q.np;
            CTRL_BITS_O <= xp_q.cs;
        end
    end

    // Lane rate is device clock times R, given in eighths
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PLL_R8_O     <= 6'h00;
            PLL_BYPASS_O <= 1'b0;
        end else begin
            PLL_R8_O     <= xp_q.r8;
            PLL_BYPASS_O <= xp_q.valid & (xp_q.r8 == BYPASS_R8);
        end
    end

    // Core input routing and sampling phase
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ADC_A_SRC_O       <= 1'b0;
            ADC_B_SRC_O       <= 1'b1;
            ADC_B_PHASE_INV_O <= 1'b0;
            DUAL_INTLV_O      <= 1'b0;
        end else begin
            ADC_A_SRC_O       <= xp_q.des & sel_b_w;
            ADC_B_SRC_O       <= ~xp_q.des | sel_b_w | sel_both_w;
            ADC_B_PHASE_INV_O <= xp_q.des;
            DUAL_INTLV_O      <= xp_q.valid & xp_q.des & sel_both_w;
        end
    end

    assign PRDATA_O  = prdata_q;
    assign PREADY_O  = pready_q;
    assign PSLVERR_O = pslverr_q;

endmodule

`default_nettype wire

// file: sim/jmip_rx_model.sv
// Receiver model that walks the alignment-sequence octets of one lane
`timescale 1ns/1ps
`default_nettype none

module jmip_rx_model (
    // Clock
    input  wire logic       clk_i,
    // Octet lookup
    output logic      [3:0] lane_o,
    output logic      [3:0] idx_o,
    input  wire logic [7:0] octet_i
);
    logic [7:0] oct_q [14];
    logic       sum_ok_q;

    initial begin
        lane_o = 4'h0;
        idx_o = 4'hF;
        sum_ok_q = 1'b0;
    end

    // Field sum of one octet, packed fields added apart
    function automatic logic [7:0] fsum(input int i, input logic [7:0] o);
        case (i)
            3: return {7'h00, o[7]} + {3'h0, o[4:0]};
            7: return {6'h00, o[7:6]} + {3'h0, o[4:0]};
            8, 9: return {5'h00, o[7:5]} + {3'h0, o[4:0]};
            13: return 8'h00;
            default: return o;
        endcase
    endfunction

    // Slow stalls between lookups
    task automatic read_lane(input logic [3:0] ln, input int slow);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 14; i++) begin
            lane_o <= ln;
            idx_o <= 4'(i);
            repeat (2 + slow) @(posedge clk_i);
            oct_q[i] = octet_i;
            s += fsum(i, octet_i);
        end
        sum_ok_q = (s === oct_q[13]);
        idx_o <= 4'hF;
        @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// file: sim/jmip_top_properties.sv
// Concurrent checks on the ports of the mode decode block
`timescale 1ns/1ps
`default_nettype none

module jmip_top_properties #(
    parameter logic [5:0] BYPASS_R8 = 6'h00
) (
    // Watched ports
    input wire logic       CLK_I, NRST_I, PSEL_I, PENABLE_I, PREADY_O, LINK_ACTIVE_O,
    input wire logic       ILAS_EN_O, ENC_64B66B_O, SCR_EN_O, DES_O, PLL_BYPASS_O,
    input wire logic       ADC_A_SRC_O, ADC_B_SRC_O, ADC_B_PHASE_INV_O, DUAL_INTLV_O,
    input wire logic [3:0] ILAS_IDX_I, LANES_O, CONVS_O, OCTETS_O,
    input wire logic [7:0] ILAS_OCTET_O, LMFC_KFM_O, MB_PER_EMB_O,
    input wire logic [5:0] PLL_R8_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    chk_ready_pulse: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
        else $error("ready is not one pulse");
    chk_zero_fields: assert property (
        ILAS_IDX_I inside {4'h1, [4'hA:4'hC], 4'hE, 4'hF} |=> ILAS_OCTET_O == 8'h00)
        else $error("fixed octet not zero");
    chk_cs_zero: assert property (
        ILAS_IDX_I == 4'h7 |=> ILAS_OCTET_O[7:5] == 3'h0) else $error("cs field not zero");
    chk_version_one: assert property (
        ILAS_IDX_I inside {4'h8, 4'h9} |=> ILAS_OCTET_O[7:5] == 3'h1)
        else $error("version field not one");
    chk_lane_octet: assert property (
        LINK_ACTIVE_O && ILAS_IDX_I == 4'h3 ##1 LINK_ACTIVE_O
        |-> ILAS_OCTET_O == {SCR_EN_O, 3'h0, LANES_O - 4'h1}) else $error("lane octet wrong");
    chk_emb_enc: assert property (
        MB_PER_EMB_O == {7'h00, ENC_64B66B_O}) else $error("multiblock count wrong");
    chk_k_ignored: assert property (
        ENC_64B66B_O |-> LMFC_KFM_O == 8'h00) else $error("K used in 64b66b");
    chk_ilas_enable: assert property (
        ILAS_EN_O == (LINK_ACTIVE_O && !ENC_64B66B_O)) else $error("ilas enable wrong");
    chk_dual_input: assert property (
        DUAL_INTLV_O |-> DES_O && ADC_B_PHASE_INV_O && !ADC_A_SRC_O && ADC_B_SRC_O)
        else $error("dual input cores wrong");
    chk_pll_bypass: assert property (
        PLL_BYPASS_O |-> PLL_R8_O == BYPASS_R8) else $error("bypass at wrong ratio");
    chk_hold_applied: assert property (
        LINK_ACTIVE_O ##1 LINK_ACTIVE_O |-> $stable({DES_O, LANES_O, CONVS_O, OCTETS_O}))
        else $error("applied set changed while on");
endmodule

bind jmip_top jmip_top_properties #(.BYPASS_R8(BYPASS_R8)) chk_i (.*);

`default_nettype wire

// file: sim/test_jmip_top.sv
// Self-checking bench for the mode decode and alignment-sequence block
`timescale 1ns/1ps
`default_nettype none
`include "jmip_cfg.svh"

module test_jmip_top;
    logic        CLK_I, NRST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, er;
    logic        LINK_ACTIVE_O, ILAS_EN_O, ENC_64B66B_O, SCR_EN_O, DES_O, PLL_BYPASS_O;
    logic        ADC_A_SRC_O, ADC_B_SRC_O, ADC_B_PHASE_INV_O, DUAL_INTLV_O, ds, sc;
    logic [11:0] PADDR_I;
    logic [31:0] PWDATA_I, PRDATA_O, seed, rd;
    logic [3:0]  PSTRB_I, ILAS_LANE_I, ILAS_IDX_I, LANES_O, CONVS_O, OCTETS_O, SAMPLES_O;
    logic [3:0]  l, m, f, s, ln;
    logic [7:0]  ILAS_OCTET_O, LMFC_KFM_O, MB_PER_EMB_O, did, kfm, lid;
    logic [4:0]  RES_O, NPRIME_O, n, np;
    logic [1:0]  CTRL_BITS_O, cs, ins;
    logic [5:0]  PLL_R8_O, md, r8;
    int          errors, cmp_count;
    // Mode, DES, L, M, F, S, N, N', CS, R*8
    logic [40:0] modes [6] = '{
        {6'h00, 1'h1, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0C, 5'h0C, 2'h0, 6'h20},
        {6'h02, 1'h0, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0C, 5'h0C, 2'h0, 6'h20},
        {6'h06, 1'h1, 4'h8, 4'h1, 4'h1, 4'h8, 5'h08, 5'h08, 2'h0, 6'h0A},
        {6'h0D, 1'h0, 4'h1, 4'h2, 4'h4, 4'h1, 5'h0F, 5'h10, 2'h1, 6'h28},
        {6'h10, 1'h0, 4'h8, 4'h2, 4'h2, 4'h4, 5'h0F, 5'h10, 2'h1, 6'h05},
        {6'h15, 1'h1, 4'h2, 4'h1, 4'h2, 4'h2, 5'h0F, 5'h10, 2'h1, 6'h28}};

    jmip_top uut (.*);
    jmip_rx_model rx (.clk_i(CLK_I), .lane_o(ILAS_LANE_I), .idx_o(ILAS_IDX_I),
                      .octet_i(ILAS_OCTET_O));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [7:0] exp_oct(input int i);
        logic [7:0] c;
        c = did + lid + sc + 8'(l - 1) + 8'(f - 1) + kfm + 8'(m - 1) + 8'(n - 1) + 8'h01
            + 8'(np - 1) + 8'h01 + 8'(s - 1);
        case (i)
            0: return did;
            2: return lid;
            3: return {sc, 3'h0, l - 4'h1};
            4: return 8'(f - 4'h1);
            5: return kfm;
            6: return 8'(m - 4'h1);
            7: return {3'h0, n - 5'h01};
            8: return {3'h1, np - 5'h01};
            9: return {3'h1, 5'(s - 4'h1)};
            13: return c;
            default: return 8'h00;
        endcase
    endfunction

    task automatic stop_test();
        $display("Compared %0d, mismatched %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK_I);
            k++;
        end while (PREADY_O !== 1'b1 && k < 50);
        rd = PRDATA_O;
        er = PSLVERR_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
        if (k >= 50) begin
            errors++;
            stop_test();
        end
        @(posedge CLK_I);
    endtask

    task automatic apply(input logic [5:0] mo, input logic [7:0] k1, input logic [1:0] cb);
        apb(1'b1, `JMIP_ADDR_CTRL, 32'h0);
        apb(1'b1, `JMIP_ADDR_MODE, 32'(mo));
        apb(1'b1, `JMIP_ADDR_KPARAM, 32'(k1));
        apb(1'b1, `JMIP_ADDR_DEVID, 32'(did));
        apb(1'b1, `JMIP_ADDR_INSEL, 32'(ins));
        apb(1'b1, `JMIP_ADDR_CTRL, 32'(cb));
        repeat (4) @(posedge CLK_I);
    endtask

    initial begin
        CLK_I = 1'b0;
        forever #50 CLK_I = ~CLK_I;
    end

    initial begin
        {NRST_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = '0;
        PSTRB_I = 4'hF;
        errors = 0;
        cmp_count = 0;
        seed = 32'h17A808D3;
        repeat (20) @(posedge CLK_I);
        NRST_I <= 1'b1;
        @(posedge CLK_I);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk("reset value", (i == 2) ? 32'h1F : 32'h0, rd);
        end
        apb(1'b1, 12'h024, 32'hFFFFFFFF);
        chk("unmapped error", 1'b1, er);
        $display("register reset test done");
        for (int t = 0; t < 6; t++) begin
            {md, ds, l, m, f, s, n, np, cs, r8} = modes[t];
            seed = lfsr(seed);
            did = seed[7:0];
            kfm = {seed[10:8], 5'h1F};
            sc = seed[11];
            ins = 2'(seed[13:12] % 3);
            ln = 4'(int'(seed[17:14]) % (2 * int'(l)));
            lid = 8'((ln < l) ? ln : ln - l);
            apply(md, kfm, {sc, 1'b1});
            chk("format", {ds, l, m, f, s, n, np, cs, r8, 1'b0},
                {DES_O, LANES_O, CONVS_O, OCTETS_O, SAMPLES_O, RES_O, NPRIME_O, CTRL_BITS_O,
                 PLL_R8_O, PLL_BYPASS_O});
            chk("cores", {ds && ins == 2'h2, ds && ins == 2'h1, !ds || ins != 2'h0, ds},
                {DUAL_INTLV_O, ADC_A_SRC_O, ADC_B_SRC_O, ADC_B_PHASE_INV_O});
            chk("link", {3'b110, sc, kfm, 8'h00},
                {LINK_ACTIVE_O, ILAS_EN_O, ENC_64B66B_O, SCR_EN_O, LMFC_KFM_O, MB_PER_EMB_O});
            apb(1'b0, `JMIP_ADDR_XPORT, 32'h0);
            chk("xport reg", {cs, 1'b0, np, 3'h0, n, s, f, m, l}, rd);
            rx.read_lane(ln, int'(seed[19:18]));
            for (int i = 0; i < 14; i++) begin
                chk("octet", exp_oct(i), rx.oct_q[i]);
            end
            chk("checksum", 1'b1, rx.sum_ok_q);
            apb(1'b1, `JMIP_ADDR_MODE, 32'h4);
            repeat (4) @(posedge CLK_I);
            chk("held", {1'b1, l}, {LINK_ACTIVE_O, LANES_O});
            $display("mode %0d test done", md);
        end
        apply(6'h04, 8'h1F, 2'h1);
        chk("reserved mode", 1'b0, LINK_ACTIVE_O);
        apply(6'h00, 8'h04, 2'h1);
        apb(1'b0, `JMIP_ADDR_STATUS, 32'h0);
        chk("illegal K", 2'h3, {rd[4], rd[0]});
        $display("reserved and K tests done");
        stop_test();
    end
endmodule

`default_nettype wire
